// File: verilog/i2c_hs_pkg.sv
// Shared constants and types for the high-speed and alert-response slave logic
package i2c_hs_pkg;
  localparam logic [3:0] BYTE_BITS = 4'h8;          // Bits in one serial byte
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;    // Upper five bits of the master code
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;   // Broadcast alert response address
  localparam logic [2:0] OWN_ADDR_BASE = 3'h4;      // Fixed upper bits of own address
  localparam logic ALERT_TAIL_BIT = 1'h0;           // Last bit sent after own address
  localparam logic HS_MODE_RESET = 1'h0;            // Filters start in standard/fast setting
  localparam int SYNC_WIDTH = 6;                    // Pins passed through the synchroniser

  // Raw pin levels, all from outside the clock domain
  typedef struct packed {
    logic scl;            // Serial clock level
    logic sda;            // Serial data level
    logic [1:0] sel_high; // Strap code of addr_select_pin_high
    logic [1:0] sel_low;  // Strap code of addr_select_pin_low
  } bus_pins_t;

  // Protocol phases of the slave
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_SEND,
    ST_WAIT
  } slave_state_t;
endpackage

// File: verilog/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import i2c_hs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire bus_pins_t pins_async,
  output bus_pins_t pins_sync
);
  bus_pins_t stage1; // First stage, read only by the second stage
  bus_pins_t stage2; // Second stage, safe for logic

  // Idle bus lines read high, so reset to the released level
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1 <= '{scl: 1'b1, sda: 1'b1, sel_high: 2'h0, sel_low: 2'h0};
      stage2 <= '{scl: 1'b1, sda: 1'b1, sel_high: 2'h0, sel_low: 2'h0};
    end else begin
      stage1 <= pins_async;
      stage2 <= stage1;
    end
  end

  assign pins_sync = stage2;
endmodule
`default_nettype wire

// File: verilog/i2c_hs_alert_slave.sv
// Serial slave core: high-speed mode entry/exit and alert response arbitration
// Function
// RULE1: Byte 00001xxx after start is master code
// RULE2: Master sends master code at most 400kHz
// RULE3: Master code unacknowledged, filters switch to high-speed
// RULE4: Repeated start follows; normal protocol, faster clock
// RULE5: Master should prefer repeated starts in high-speed
// RULE6: Stop leaves high-speed, filters back to standard
// RULE7: Respond to alert address 0001100 with read
// RULE8: Pending alert: acknowledge, then send own address
// RULE9: Arbitration loser stops, alert stays low until cleared
// RULE10: Own address from select pins, every transaction
// RULE11: Reset starts in standard/fast, high-speed filtering off
`timescale 1ns/1ps
`default_nettype none
module i2c_hs_alert_slave
  import i2c_hs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_select_pin_high,
  input wire logic [1:0] addr_select_pin_low,
  input wire logic alert_pending,
  output logic alert_out,
  output logic alert_oe,
  output logic hs_mode,
  output logic alert_won,
  output logic alert_lost
);
  bus_pins_t pins_raw;  // Pins gathered for the synchroniser
  bus_pins_t pins;      // Synchronised pins
  logic scl_prev;       // Clock level one cycle ago
  logic sda_prev;       // Data level one cycle ago
  logic scl_rise;       // Serial clock rising edge
  logic scl_fall;       // Serial clock falling edge
  logic start_cond;     // Start or repeated start seen
  logic stop_cond;      // Stop seen
  logic decode_now;     // Eighth bit done, byte ready to judge
  slave_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;     // Bits seen or sent in this byte
  logic [7:0] shreg, next_shreg;         // Received byte
  logic [7:0] tx, next_tx;               // Byte being sent, msb first
  logic drive_low, next_drive_low;       // Pull data line low
  logic next_hs_mode;
  logic [6:0] own_addr, next_own_addr;   // Address caught at the last start
  logic is_alert, next_is_alert;         // Current transfer is an alert response
  logic next_alert_won;
  logic next_alert_lost;

  assign pins_raw = '{scl: scl_in, sda: sda_in, sel_high: addr_select_pin_high,
                      sel_low: addr_select_pin_low};

  pin_sync u_sync (
    .clock(clock),
    .reset(reset),
    .pins_async(pins_raw),
    .pins_sync(pins)
  );

  // Edge history of the synchronised lines
  always_ff @(posedge clock) begin
    if (reset) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= pins.scl;
      sda_prev <= pins.sda;
    end
  end

  // Bus events; data moving while the clock is high marks start or stop
  always_comb begin
    scl_rise = pins.scl & ~scl_prev;
    scl_fall = ~pins.scl & scl_prev;
    start_cond = pins.scl & scl_prev & sda_prev & ~pins.sda;
    stop_cond = pins.scl & scl_prev & ~sda_prev & pins.sda;
    decode_now = (state == ST_ADDR) & ~start_cond & ~stop_cond & scl_fall &
                 (bit_cnt == BYTE_BITS);
  end

  // Next-state logic for the whole slave
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx = tx;
    next_drive_low = drive_low;
    next_hs_mode = hs_mode;
    next_own_addr = own_addr;
    next_is_alert = is_alert;
    next_alert_won = 1'b0;
    next_alert_lost = 1'b0;
    if (stop_cond) begin
      // Stop always ends high-speed, even mid-byte
      next_state = ST_IDLE;
      next_drive_low = 1'b0;
      next_hs_mode = 1'b0; // RULE6
    end else if (start_cond) begin
      // Repeated start keeps the current speed setting
      next_state = ST_ADDR; // RULE4
      next_bit_cnt = 4'h0;
      next_drive_low = 1'b0;
      next_own_addr = {OWN_ADDR_BASE, pins.sel_high, pins.sel_low}; // RULE10
    end else begin
      case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], pins.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (decode_now) begin
            if (shreg[7:3] == HS_CODE_PREFIX) begin
              // Recognised but left unacknowledged
              next_hs_mode = 1'b1; // RULE1 RULE3
              next_state = ST_WAIT;
            end else if (shreg[7:1] == ALERT_RESP_ADDR && shreg[0] && alert_pending) begin
              next_drive_low = 1'b1; // RULE7 RULE8
              next_is_alert = 1'b1;
              next_state = ST_ACK;
            end else if (shreg[7:1] == own_addr) begin
              // Own address: acknowledge, payload handled elsewhere
              next_drive_low = 1'b1;
              next_is_alert = 1'b0;
              next_state = ST_ACK;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (is_alert) begin
              // Present own address first bit as the acknowledge ends
              next_tx = {own_addr, ALERT_TAIL_BIT}; // RULE8
              next_drive_low = ~own_addr[6];
              next_bit_cnt = 4'h0;
              next_state = ST_SEND;
            end else begin
              next_drive_low = 1'b0;
              next_state = ST_WAIT;
            end
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
            // Released a one but line reads low: another responder won
            if (~drive_low && ~pins.sda) begin
              next_alert_lost = 1'b1; // RULE9
              next_state = ST_WAIT;
            end
          end else if (scl_fall) begin
            if (bit_cnt == BYTE_BITS) begin
              next_drive_low = 1'b0;
              next_alert_won = 1'b1;
              next_state = ST_WAIT;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_drive_low = ~tx[6];
            end
          end
        end
        default: begin
          // Idle and wait phases ignore bits until start or stop
          next_state = state;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      drive_low <= 1'b0;
      hs_mode <= HS_MODE_RESET; // RULE11
      own_addr <= 7'h00;
      is_alert <= 1'b0;
      alert_won <= 1'b0;
      alert_lost <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx <= next_tx;
      drive_low <= next_drive_low;
      hs_mode <= next_hs_mode;
      own_addr <= next_own_addr;
      is_alert <= next_is_alert;
      alert_won <= next_alert_won;
      alert_lost <= next_alert_lost;
    end
  end

  // Open-drain drivers only ever pull low; a loser keeps alert low until cleared
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  assign alert_out = 1'b0;
  assign alert_oe = alert_pending; // RULE9

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_ara_ack;
    (state == ST_ACK) && is_alert && scl_fall && !start_cond && !stop_cond;
  endsequence

  property p_hs_enter;
    decode_now && shreg[7:3] == HS_CODE_PREFIX |=> hs_mode && state == ST_WAIT;
  endproperty
  a_hs_enter: assert property (p_hs_enter) else $error("master code not taken"); // RULE1

  property p_hs_noack;
    decode_now && shreg[7:3] == HS_CODE_PREFIX |=> !sda_oe [*2];
  endproperty
  a_hs_noack: assert property (p_hs_noack) else $error("master code acknowledged"); // RULE3

  property p_hs_keep;
    hs_mode && start_cond |=> hs_mode && state == ST_ADDR;
  endproperty
  a_hs_keep: assert property (p_hs_keep) else $error("repeated start dropped speed"); // RULE4

  property p_hs_exit;
    stop_cond |=> !hs_mode && !sda_oe;
  endproperty
  a_hs_exit: assert property (p_hs_exit) else $error("stop kept high speed"); // RULE6

  property p_ara_ack;
    decode_now && shreg == {ALERT_RESP_ADDR, 1'b1} && alert_pending |=> sda_oe && is_alert;
  endproperty
  a_ara_ack: assert property (p_ara_ack) else $error("alert address not acknowledged"); // RULE7

  property p_ara_send;
    s_ara_ack |=> state == ST_SEND && sda_oe == !own_addr[6] && tx[7:1] == own_addr;
  endproperty
  a_ara_send: assert property (p_ara_send) else $error("own address not sent"); // RULE8

  property p_arb_lose;
    state == ST_SEND && scl_rise && !drive_low && !pins.sda && !start_cond && !stop_cond
      |=> !sda_oe && alert_lost && state == ST_WAIT;
  endproperty
  a_arb_lose: assert property (p_arb_lose) else $error("lost arbitration kept driving"); // RULE9

  property p_addr_pins;
    start_cond && !stop_cond
      |=> own_addr == {OWN_ADDR_BASE, $past(pins.sel_high), $past(pins.sel_low)};
  endproperty
  a_addr_pins: assert property (p_addr_pins) else $error("address not from pins"); // RULE10

  property p_reset_fs;
    @(posedge clock) disable iff (1'b0) $past(reset) |-> !hs_mode && !sda_oe;
  endproperty
  a_reset_fs: assert property (p_reset_fs) else $error("reset left high speed"); // RULE11
endmodule
`default_nettype wire

// File: testbench/i2c_master_model.sv
// Behavioural bus master that drives the serial clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Quarter of a bit time in system clocks; slow by default, lowered for high speed
  int quarter = 66;
  // Bus idles released; the pull-ups hold both lines high
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // Wait n quarter bits, always ending on a falling system clock edge
  task automatic hold(input int n);
    repeat (n * quarter) @(negedge clock);
  endtask
  // Start and repeated start share one waveform
  task automatic start();
    sda_low = 1'h0;
    hold(1);
    scl = 1'h1;
    hold(2);
    sda_low = 1'h1;
    hold(2);
    scl = 1'h0;
    hold(1);
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'h1;
    hold(1);
    scl = 1'h1;
    hold(2);
    sda_low = 1'h0;
    hold(2);
  endtask
  // One bit: data set mid-low, line sampled mid-high
  task automatic bit_xfer(input logic b, output logic r);
    sda_low = !b;
    hold(1);
    scl = 1'h1;
    hold(1);
    r = sda;
    hold(1);
    scl = 1'h0;
    hold(1);
  endtask
  // Byte then ninth bit, msb first; send 8'hFF to read, ack_in=1 to release the ack slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], q[i]);
    end
    bit_xfer(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// File: testbench/i2c_hs_mode_alert_response_tb.sv
// Self-checking bench for high-speed entry/exit and alert response arbitration
`timescale 1ns/1ps
`default_nettype none
module i2c_hs_mode_alert_response_tb;
  import i2c_hs_pkg::*;
  localparam int FS_QUARTER = 66; // Slow bit of 2.64 us, below the 400 kHz ceiling
  localparam int HS_QUARTER = 8; // Fast bit of 320 ns, below the 3.4 MHz ceiling
  localparam int TIMEOUT_CYCLES = 40000; // Run needs about 27k cycles
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic scl, m_low, rival_low, sda_oe, alert_pending, alert_oe, hs_mode, won, lost;
  logic alert_won, alert_lost, a;
  logic [1:0] sel_h, sel_l;
  logic [7:0] q;
  logic [31:0] seed, r;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  wire logic sda = !(m_low | sda_oe | rival_low); // Open drain with pull-up
  always #5 clock = !clock;
  i2c_master_model m (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));
  i2c_hs_alert_slave dut (.clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .addr_select_pin_high(sel_h), .addr_select_pin_low(sel_l),
    .alert_pending(alert_pending), .alert_out(), .alert_oe(alert_oe), .hs_mode(hs_mode),
    .alert_won(alert_won), .alert_lost(alert_lost));
  // Sticky copies of the one-cycle result pulses, read where they have settled
  always @(negedge clock) begin
    cycles++;
    if (alert_won === 1'h1) won = 1'h1;
    if (alert_lost === 1'h1) lost = 1'h1;
    if (cycles == TIMEOUT_CYCLES) begin
      miscompares++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reply byte expected from the select straps
  function automatic logic [7:0] reply(input logic [1:0] h, input logic [1:0] l);
    return {3'h4, h, l, 1'h0};
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {rival_low, alert_pending, sel_h, sel_l, won, lost} = 8'h00;
    seed = 32'h00000010;
    repeat (16) @(negedge clock);
    reset = 1'h0;
    repeat (4) @(negedge clock);
    check("hs_mode_reset", 8'(hs_mode), 8'h00);
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      {sel_h, sel_l} = r[3:0];
      // Alert pending on even passes only
      alert_pending = (k % 2 == 0);
      won = 1'h0;
      // Master code with random low bits, sent at the slow rate
      m.quarter = FS_QUARTER;
      m.start();
      m.xfer({5'h01, r[6:4]}, 1'h1, q, a);
      check("code_ack", 8'(a), 8'h01);
      check("hs_enter", 8'(hs_mode), 8'h01);
      // Own address and alert response at high speed, joined by repeated starts
      m.quarter = HS_QUARTER;
      m.start();
      m.xfer(reply(sel_h, sel_l), 1'h1, q, a);
      check("own_ack", 8'(a), 8'h00);
      check("hs_keep", 8'(hs_mode), 8'h01);
      m.start();
      m.xfer({ALERT_RESP_ADDR, 1'h1}, 1'h1, q, a);
      check("ara_ack", 8'(a), 8'(!alert_pending));
      check("hs_keep_ara", 8'(hs_mode), 8'h01);
      if (alert_pending) begin
        m.xfer(8'hFF, 1'h1, q, a);
        check("ara_reply", q, reply(sel_h, sel_l));
        check("ara_won", 8'(won), 8'h01);
      end
      m.stop();
      check("hs_exit", 8'(hs_mode), 8'h00);
      alert_pending = 1'h0;
    end
    // Arbitration at the slow rate against a rival answering with an all-zero address
    m.quarter = FS_QUARTER;
    {sel_h, sel_l} = 4'hD;
    alert_pending = 1'h1;
    {won, lost} = 2'h0;
    m.start();
    m.xfer({ALERT_RESP_ADDR, 1'h1}, 1'h1, q, a);
    rival_low = 1'h1;
    m.xfer(8'hFF, 1'h1, q, a);
    rival_low = 1'h0;
    m.stop();
    check("arb_lost", 8'({won, lost}), 8'h01);
    check("arb_alert_held", 8'(alert_oe), 8'h01);
    alert_pending = 1'h0;
    @(negedge clock);
    check("alert_release", 8'(alert_oe), 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
